/* testbench/far_phy.sv */
`timescale 1ns/1ps
`default_nettype none
// far end line driver: nrz bits in, three-level slicer levels out
module far_phy (
    input  wire logic sys_clk,   // bit clock
    input  wire logic line_on,   // far end transmitting
    input  wire logic nrz_bit,   // next bit to send
    output logic      rx_pos,    // level plus
    output logic      rx_neg,    // level minus
    output logic      rx_energy  // energy seen on the pair
);
    logic       nrzi_q = 1'b0;  // line nrzi state
    logic [1:0] ph_q   = 2'h0;  // zero, plus, zero, minus
    logic       en_q   = 1'b0;  // registered energy
    always @(posedge sys_clk) begin
        en_q <= line_on;
        if (!line_on) begin
            // a silent pair rests at the zero level, not at the last one
            nrzi_q <= 1'b0;
            ph_q   <= 2'h0;
        end else begin
            nrzi_q <= nrzi_q ^ nrz_bit;
            if (nrzi_q ^ nrz_bit) begin
                ph_q <= ph_q + 2'h1;
            end
        end
    end
    assign rx_pos    = (ph_q == 2'h1);
    assign rx_neg    = (ph_q == 2'h3);
    assign rx_energy = en_q;
endmodule : far_phy
`default_nettype wire

/* testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import line_codec_pkg::*;
    logic       sys_clk = 0, rst_n = 0, tx_valid = 0, tx_en = 0;  // mac side
    logic       line_on = 0, nrz_bit = 0;                        // far end
    nibble_t    txd = 4'h0, rx_nibble;
    logic [4:0] strap;
    logic       tx_ready, tx_pos, tx_neg, rx_pos, rx_neg, rx_energy, signal_detect;
    logic       rx_nrz, rx_nrz_valid, rx_nibble_valid, rx_er;
    int         n_fail = 0, comparisons = 0, seed = 48205, off = -1, j = 0;
    logic       s_q[$], k[$];       // recovered line bits, keystream
    logic [4:0] rxq[$];             // received {error, nibble}
    nibble_t    dat[$];             // nibbles sent
    logic       chg_q = 0, sd_seen = 0, saw_full = 0, ok;
    logic [1:0] pair_q = 2'h0;
    // our own copy of the code table, kept apart from the design's
    localparam logic [4:0] TBL [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b,
        5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};

    always #50 sys_clk = ~sys_clk;

    line_codec dut_u (.sys_clk, .rst_n, .tx_valid, .tx_ready, .tx_en, .txd,
        .phy_address_strap(strap), .tx_pos, .tx_neg, .rx_pos, .rx_neg, .rx_energy,
        .signal_detect, .rx_nrz, .rx_nrz_valid, .rx_nibble, .rx_nibble_valid, .rx_er);
    far_phy peer_u (.sys_clk, .line_on, .nrz_bit, .rx_pos, .rx_neg, .rx_energy);

    task automatic check_flag(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask : check_flag

    task automatic check_code(input logic [4:0] got, input logic [4:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: code %h, expected %h", $time, got, exp);
        end
    endtask : check_code

    task automatic summarize;
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize

    // mac write, held until the queue takes it
    task automatic push(input logic en, input nibble_t d);
        tx_valid <= 1'b1;
        tx_en    <= en;
        txd      <= d;
        do begin
            @(posedge sys_clk);
            if (tx_ready === 1'b0) saw_full = 1'b1;
        end while (tx_ready !== 1'b1);
    endtask : push

    // one code-group onto the cable, msb first
    task automatic send_grp(input logic [4:0] c);
        for (int b = 4; b >= 0; b--) begin
            nrz_bit <= c[b];
            @(posedge sys_clk);
        end
    endtask : send_grp

    // descrambled line group starting at bit i
    function automatic logic [4:0] grp(input int i);
        logic [4:0] g;
        g = 5'h00;
        for (int b = 0; b < 5; b++) g = {g[3:0], s_q[off+i+b] ^ k[i+b]};
        return g;
    endfunction : grp

    // line monitor: a level change is an nrzi one, nrz is its difference
    always @(posedge sys_clk) begin
        if (rst_n) begin
            check_flag(tx_pos & tx_neg, 1'b0);
            check_flag(({tx_pos, tx_neg} != pair_q) && pair_q != 0 && {tx_pos, tx_neg} != 0, 1'b0);
            s_q.push_back(({tx_pos, tx_neg} != pair_q) ^ chg_q);
            chg_q  <= ({tx_pos, tx_neg} != pair_q);
            pair_q <= {tx_pos, tx_neg};
        end
        if (rx_nibble_valid === 1'b1) rxq.push_back({rx_er, rx_nibble});
        if (signal_detect === 1'b1) sd_seen <= 1'b1;
    end

    // watchdog, well beyond the expected run of about 820 cycles
    initial begin
        #(3000 * 100);
        n_fail++;
        summarize();
    end

    initial begin
        strap = 5'($random(seed));
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        check_flag(tx_pos | tx_neg | signal_detect, 1'b0);
        // short link pulses only
        repeat (5) begin
            line_on <= 1'b1;
            repeat (2) @(posedge sys_clk);
            line_on <= 1'b0;
            repeat (30) @(posedge sys_clk);
        end
        check_flag(sd_seen, 1'b0);
        line_on <= 1'b1;
        nrz_bit <= 1'b1;
        repeat (8) @(posedge sys_clk);
        check_flag(signal_detect, 1'b0);
        repeat (12) @(posedge sys_clk);
        check_flag(signal_detect, 1'b1);
        // receive: idles, start pair, data, a stray idle, end pair
        repeat (6) send_grp(5'h1f);
        check_flag(rx_nrz & rx_nrz_valid, 1'b1);
        send_grp(5'h18);
        send_grp(5'h11);
        for (int i = 0; i < 12; i++) begin
            dat.push_back(4'($random(seed)));
            send_grp(TBL[dat[i]]);
        end
        send_grp(5'h1f);
        send_grp(5'h0d);
        send_grp(5'h07);
        repeat (4) send_grp(5'h1f);
        repeat (10) @(posedge sys_clk);
        check_code(5'(rxq.size()), 5'd13);
        for (int i = 0; i < 12; i++) check_code(rxq[i], {1'b0, dat[i]});
        check_flag(rxq[12][4], 1'b1);
        // transmit: long frame so the queue fills and refuses
        dat.delete();
        repeat (2) push(1'b1, 4'h5);
        for (int i = 0; i < 45; i++) begin
            dat.push_back(4'($random(seed)));
            push(1'b1, dat[i]);
        end
        push(1'b0, 4'h0);
        tx_valid <= 1'b0;
        check_flag(saw_full, 1'b1);
        repeat (400) @(posedge sys_clk);
        // keystream from the strap seed, x^11 + x^9 + 1
        for (int i = 0; i < 11; i++) k.push_back(1'({strap[4:1], 7'h5b} >> (10 - i)));
        while (k.size() < s_q.size()) k.push_back(k[$-10] ^ k[$-8]);
        for (int o = 0; o < 40; o++) begin
            ok = 1'b1;
            for (int i = 0; i < 60; i++) if ((s_q[o+i] ^ k[i]) !== 1'b1) ok = 1'b0;
            if (ok && off < 0) off = o;
        end
        check_flag(off >= 0, 1'b1);
        j = 5;
        while (j < 3000 && {grp(j), grp(j + 5)} !== 10'h311) j++;
        check_code(grp(j - 5), 5'h1f);
        check_code(grp(j + 10), TBL[dat[0]]);
        for (int i = 1; i < 45; i++) check_code(grp(j + 10 + 5 * i), TBL[dat[i]]);
        check_code(grp(j + 235), 5'h0d);
        check_code(grp(j + 240), 5'h07);
        check_code(grp(j + 245), 5'h1f);
        summarize();
    end
endmodule : tb
`default_nettype wire

/* verilog/line_codec.sv */
// Notes on behaviour
// RULE_01: each nibble becomes a 5-bit code-group
// RULE_02: first two preamble nibbles become J, K
// RULE_03: later nibbles map to code-groups in order
// RULE_04: enable falling appends T then R
// RULE_05: idle code-groups fill between frames
// RULE_06: mac holds enable over whole frame
// RULE_07: 11-bit lfsr output xored with nrz
// RULE_08: seed taken from strap bits four:one
// RULE_09: scrambled bits are nrzi encoded
// RULE_10: ones alternate between two driver streams
// RULE_11: only three-level output, no binary mode
// RULE_12: receive stream delivered as 4-bit nibbles
// RULE_13: link pulses never raise signal detect
// RULE_14: three-level symbols decoded to nrzi
// RULE_15: nrzi converted back to nrz
// RULE_16: standard code table, idle and halt
// RULE_17: control codes in data flag error
// RULE_18: nrzi toggles on one; decode differences
// RULE_19: polynomial x11+x9+1, seed never zero
// RULE_20: level cycles zero plus zero minus
`timescale 1ns/1ps
`default_nettype none
`include "line_codec_map.svh"
module line_codec
    import line_codec_pkg::*;
(
    input  wire logic                 sys_clk,           // 10 MHz bit clock
    input  wire logic                 rst_n,             // sync reset, low
    input  wire logic                 tx_valid,          // mac offers a nibble
    output logic                      tx_ready,          // queue has room
    input  wire logic                 tx_en,             // frame enable with nibble
    input  wire line_codec_pkg::nibble_t txd,            // transmit nibble
    input  wire logic [4:0]           phy_address_strap, // address straps
    output logic                      tx_pos,            // driver plus side
    output logic                      tx_neg,            // driver minus side
    input  wire logic                 rx_pos,            // slicer saw plus
    input  wire logic                 rx_neg,            // slicer saw minus
    input  wire logic                 rx_energy,         // analog energy present
    output logic                      signal_detect,     // qualified signal
    output logic                      rx_nrz,            // recovered nrz bit
    output logic                      rx_nrz_valid,      // rx_nrz carries a bit
    output line_codec_pkg::nibble_t   rx_nibble,         // decoded nibble
    output logic                      rx_nibble_valid,   // nibble strobe
    output logic                      rx_er              // code error strobe
);
    import line_codec_pkg::*;

    stream_fifo_if #(.W(`CG_W)) txq();   // {tx_en, txd} queue

    stream_fifo #(.W(`CG_W), .DEPTH(`TXQ_DEPTH)) u_txq (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .q       (txq.fifo)
    );

    assign txq.push_valid = tx_valid;
    assign txq.push_data  = {tx_en, txd};
    assign tx_ready       = txq.push_ready;

    // ---------------- pin synchronisers ----------------
    logic [3:0] st1_q, st2_q, st3_q;                  // strap bits four:one
    logic [3:0] strap_q;                              // agreed strap value
    logic [2:0] rx1_q, rx2_q, rx3_q;                  // {energy, neg, pos}
    logic [2:0] rxs_q, rxs_d;                         // rx pins, only energy agreed

    // first stage feeds only the second
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st1_q <= '0; st2_q <= '0; st3_q <= '0;
            rx1_q <= '0; rx2_q <= '0; rx3_q <= '0;
        end else begin
            st1_q <= phy_address_strap[4:1];
            st2_q <= st1_q;
            st3_q <= st2_q;
            rx1_q <= {rx_energy, rx_neg, rx_pos};
            rx2_q <= rx1_q;
            rx3_q <= rx2_q;
        end
    end

    // slicer levels may last a single bit time, so waiting for two stages
    // to agree would swallow them; they pass the third stage as they are
    always_comb begin
        rxs_d = {rxs_q[2], rx3_q[1:0]};
        // energy is slow: it counts once stages two and three agree
        if (rx2_q[2] == rx3_q[2]) begin
            rxs_d[2] = rx3_q[2];
        end
    end

    // ---------------- transmit encoder ----------------
    enc_state_t state_q, state_d;      // frame position
    code_t      sym_q, sym_d;          // code-group being shifted out
    logic [2:0] bit_q, bit_d;          // bit within code-group
    logic [1:0] wait_q, wait_d;        // settle time before seed load
    logic       run_q, run_d;          // seed loaded, line active
    logic [`SCR_MSB:0] lfsr_q, lfsr_d; // scrambler state
    logic [3:0] strap_d;               // agreed strap next
    logic       nrzi_q, nrzi_d;        // nrzi line bit
    mlt_phase_t phase_q, phase_d;      // three-level phase
    logic       pos_d, neg_d;          // driver streams next
    logic       slot;                  // last bit of a code-group
    logic       head_en;               // enable flag of queue head
    logic       scr_bit;               // scrambled nrz bit

    assign slot    = run_q && (bit_q == `BIT_LAST);
    assign head_en = txq.pop_data[`NIB_W];
    // RULE_07 scrambler output xor
    assign scr_bit = sym_q[`CG_W-1] ^ lfsr_q[`SCR_MSB];

    // encoder, serializer, scrambler, nrzi and three-level next state
    always_comb begin
        state_d       = state_q;
        sym_d         = sym_q;
        bit_d         = bit_q;
        wait_d        = wait_q;
        run_d         = run_q;
        lfsr_d        = lfsr_q;
        nrzi_d        = nrzi_q;
        phase_d       = phase_q;
        strap_d       = (st2_q == st3_q) ? st3_q : strap_q;
        txq.pop_ready = 1'b0;
        if (!run_q) begin
            // RULE_08 seed from settled straps
            if (wait_q == `SEED_WAIT) begin
                run_d  = 1'b1;
                // RULE_19 fill bits keep the seed nonzero
                // strap_d: the agreed value lands in strap_q on this same edge
                lfsr_d = {strap_d, `SCR_SEED_FILL};
            end else begin
                wait_d = wait_q + 2'h1;
            end
        end else begin
            // RULE_19 x^11 + x^9 + 1 feedback
            lfsr_d = {lfsr_q[`SCR_MSB-1:0], lfsr_q[`SCR_MSB] ^ lfsr_q[`SCR_TAP]};
            // RULE_09 nrzi of scrambled stream
            // RULE_18 toggle on one, hold on zero
            nrzi_d = nrzi_q ^ scr_bit;
            // RULE_20 advance phase on each nrzi one
            phase_d = nrzi_q ? mlt_phase_t'(phase_q + 2'h1) : phase_q;
            if (slot) begin
                bit_d = 3'h0;
                // RULE_01 one code-group per nibble
                case (state_q)
                    ENC_IDLE: begin
                        txq.pop_ready = txq.pop_valid;
                        if (txq.pop_valid && head_en) begin
                            // RULE_02 first preamble nibble becomes J
                            sym_d   = `CG_J;
                            state_d = ENC_K;
                        end else begin
                            // RULE_05 idle fill between frames
                            sym_d = `CG_IDLE;
                        end
                    end
                    ENC_K: begin
                        // RULE_02 second preamble nibble becomes K
                        txq.pop_ready = txq.pop_valid;
                        sym_d         = `CG_K;
                        state_d       = ENC_DATA;
                    end
                    ENC_DATA: begin
                        txq.pop_ready = txq.pop_valid;
                        if (txq.pop_valid && head_en) begin
                            // RULE_03 in-order data mapping
                            // RULE_16 standard table
                            sym_d = encode_nib(txq.pop_data[`NIB_W-1:0]);
                        end else begin
                            // RULE_04 enable fell: T first
                            // RULE_06 falling enable ends frame
                            sym_d   = `CG_T;
                            state_d = ENC_R;
                        end
                    end
                    ENC_R: begin
                        // RULE_04 then R
                        sym_d   = `CG_R;
                        state_d = ENC_IDLE;
                    end
                    default: begin
                        sym_d   = `CG_IDLE;
                        state_d = ENC_IDLE;
                    end
                endcase
            end else begin
                // msb first on the wire
                sym_d = {sym_q[`CG_W-2:0], 1'b0};
                bit_d = bit_q + 3'h1;
            end
        end
        // RULE_10 plus and minus streams alternate ones
        // RULE_11 no binary output path exists
        pos_d = (phase_d == LVL_PLUS);
        neg_d = (phase_d == LVL_MINUS);
    end

    // transmit registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q <= ENC_IDLE;
            sym_q   <= `CG_IDLE;
            bit_q   <= 3'h0;
            wait_q  <= 2'h0;
            run_q   <= 1'b0;
            lfsr_q  <= {4'h0, `SCR_SEED_FILL};
            strap_q <= 4'h0;
            nrzi_q  <= 1'b0;
            phase_q <= LVL_ZERO_A;
            tx_pos  <= 1'b0;
            tx_neg  <= 1'b0;
        end else begin
            state_q <= state_d;
            sym_q   <= sym_d;
            bit_q   <= bit_d;
            wait_q  <= wait_d;
            run_q   <= run_d;
            lfsr_q  <= lfsr_d;
            strap_q <= strap_d;
            nrzi_q  <= nrzi_d;
            phase_q <= phase_d;
            tx_pos  <= pos_d;
            tx_neg  <= neg_d;
        end
    end

    // ---------------- receive front ----------------
    localparam logic [3:0] SD_CNT_MAX = 4'(`SD_QUAL_CYC);
    logic [3:0] sd_cnt_q, sd_cnt_d;     // energy qualification counter
    logic       sd_d;                   // signal detect next
    logic [1:0] lvl_q, lvl_d;           // last three-level symbol
    logic       rnrzi_q, rnrzi_d;       // recovered nrzi
    logic       rnrz_d, rnrz_v_d;       // recovered nrz and its valid
    logic [9:0] win_q, win_d;           // bit window for J/K search
    logic       infr_q, infr_d;         // aligned inside a frame
    logic [2:0] rbit_q, rbit_d;         // bit within received group
    nibble_t    rnib_d;                 // nibble out next
    logic       rnib_v_d, rer_d;        // nibble strobe and error next
    logic [`NIB_W:0] dec;               // decode of current group

    // receive next state
    always_comb begin
        dec      = '0;
        // RULE_13 link pulses are far shorter than the qualify time
        sd_cnt_d = !rxs_q[2] ? 4'h0 : (sd_cnt_q == SD_CNT_MAX) ? sd_cnt_q : sd_cnt_q + 4'h1;
        sd_d     = rxs_q[2] && (sd_cnt_q == SD_CNT_MAX);
        // RULE_14 a level step is an nrzi one, a held level a zero
        lvl_d    = rxs_q[1:0];
        rnrzi_d  = (rxs_q[1:0] != lvl_q);
        // RULE_15 nrz is one where nrzi bits differ
        rnrz_d   = rnrzi_d ^ rnrzi_q;
        rnrz_v_d = signal_detect;
        win_d    = win_q;
        infr_d   = infr_q;
        rbit_d   = rbit_q;
        rnib_d   = rx_nibble;
        rnib_v_d = 1'b0;
        rer_d    = 1'b0;
        if (!signal_detect) begin
            infr_d = 1'b0;
        end else begin
            win_d = {win_q[8:0], rnrz_d};
            dec   = decode_cg(win_d[`CG_W-1:0]);
            if (!infr_q) begin
                if (win_d == {`CG_J, `CG_K}) begin
                    infr_d = 1'b1;
                    rbit_d = 3'h0;
                end
            end else if (rbit_q == `BIT_LAST) begin
                // RULE_12 one nibble per five bits
                rbit_d   = 3'h0;
                rnib_d   = dec[`NIB_W-1:0];
                rnib_v_d = (win_d[`CG_W-1:0] != `CG_T);
                // RULE_17 control or invalid inside data
                rer_d    = !dec[`NIB_W] && (win_d[`CG_W-1:0] != `CG_T);
                infr_d   = (win_d[`CG_W-1:0] != `CG_T);
            end else begin
                rbit_d = rbit_q + 3'h1;
            end
        end
    end

    // receive registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rxs_q           <= 3'h0;
            sd_cnt_q        <= 4'h0;
            signal_detect   <= 1'b0;
            lvl_q           <= 2'h0;
            rnrzi_q         <= 1'b0;
            rx_nrz          <= 1'b0;
            rx_nrz_valid    <= 1'b0;
            win_q           <= 10'h000;
            infr_q          <= 1'b0;
            rbit_q          <= 3'h0;
            rx_nibble       <= 4'h0;
            rx_nibble_valid <= 1'b0;
            rx_er           <= 1'b0;
        end else begin
            rxs_q           <= rxs_d;
            sd_cnt_q        <= sd_cnt_d;
            signal_detect   <= sd_d;
            lvl_q           <= lvl_d;
            rnrzi_q         <= rnrzi_d;
            rx_nrz          <= rnrz_d;
            rx_nrz_valid    <= rnrz_v_d;
            win_q           <= win_d;
            infr_q          <= infr_d;
            rbit_q          <= rbit_d;
            rx_nibble       <= rnib_d;
            rx_nibble_valid <= rnib_v_d;
            rx_er           <= rer_d;
        end
    end

    // ---------------- assertions ----------------
    a_start_emits_j: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_02
        slot && state_q == ENC_IDLE && txq.pop_valid && head_en |=> sym_q == `CG_J ##5 sym_q == `CG_K)
        else $error("frame start did not send J then K");
    a_data_mapped: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_03
        slot && state_q == ENC_DATA && txq.pop_valid && head_en
        |=> sym_q == encode_nib($past(txq.pop_data[`NIB_W-1:0])))
        else $error("data nibble mis-encoded");
    a_end_t_r: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_04
        slot && state_q == ENC_DATA && !(txq.pop_valid && head_en)
        |=> sym_q == `CG_T ##5 sym_q == `CG_R)
        else $error("frame end did not send T then R");
    a_idle_fill: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_05
        slot && state_q == ENC_IDLE && !(txq.pop_valid && head_en) |=> sym_q == `CG_IDLE)
        else $error("idle not sent between frames");
    a_lfsr_live: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_19
        run_q |-> lfsr_q != '0)
        else $error("scrambler locked at zero");
    a_seed_strap: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_08
        $rose(run_q) |-> lfsr_q[`SCR_MSB:`SCR_MSB-3] == $past(st3_q))
        else $error("seed not taken from straps");
    a_level_alternate: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_10
        (tx_pos |=> !tx_neg) and (tx_neg |=> !tx_pos))
        else $error("plus stepped straight to minus");
    a_nrzi_step: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_20
        run_q && !nrzi_q && $past(run_q) |=> $stable(tx_pos) && $stable(tx_neg))
        else $error("level moved on nrzi zero");
    a_sd_qualify: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_13
        $rose(signal_detect) |-> $past(sd_cnt_q) == SD_CNT_MAX && $past(rxs_q[2], 2))
        else $error("signal detect raised on short energy");
    a_rx_error: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_17
        rx_er |-> rx_nibble_valid && $past(infr_q))
        else $error("receive error outside a data field");
endmodule : line_codec
`default_nettype wire

/* verilog/line_codec_map.svh */
`ifndef LINE_CODEC_MAP_SVH
`define LINE_CODEC_MAP_SVH
// symbol and nibble widths, transmit queue depth
`define CG_W            5
`define NIB_W           4
`define TXQ_DEPTH       32
// control code-groups
`define CG_J            5'h18
`define CG_K            5'h11
`define CG_T            5'h0d
`define CG_R            5'h07
`define CG_IDLE         5'h1f
`define CG_HALT         5'h04
// serializer and scrambler layout
`define BIT_LAST        3'h4
`define SCR_MSB         10
`define SCR_TAP         8
`define SCR_SEED_FILL   7'h5b
`define SEED_WAIT       2'h3
// timing
`define CLK_PERIOD_NS   100
`define SD_QUAL_NS      1000
`define SD_QUAL_CYC     ((`SD_QUAL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* verilog/line_codec_pkg.sv */
`default_nettype none
package line_codec_pkg;
    `include "line_codec_map.svh"

    typedef logic [`NIB_W-1:0] nibble_t;   // mii nibble
    typedef logic [`CG_W-1:0]  code_t;     // 5b code-group

    // transmit encoder position within a frame
    typedef enum logic [1:0] {
        ENC_IDLE = 2'b00,
        ENC_K    = 2'b01,
        ENC_DATA = 2'b10,
        ENC_R    = 2'b11
    } enc_state_t;

    // three-level phase: zero, plus, zero, minus
    typedef enum logic [1:0] {
        LVL_ZERO_A = 2'b00,
        LVL_PLUS   = 2'b01,
        LVL_ZERO_B = 2'b10,
        LVL_MINUS  = 2'b11
    } mlt_phase_t;

    // nibble to code-group lookup
    function automatic code_t encode_nib(input nibble_t n);
        code_t c;
        case (n)
            4'h0: c = 5'h1e;  4'h1: c = 5'h09;  4'h2: c = 5'h14;  4'h3: c = 5'h15;
            4'h4: c = 5'h0a;  4'h5: c = 5'h0b;  4'h6: c = 5'h0e;  4'h7: c = 5'h0f;
            4'h8: c = 5'h12;  4'h9: c = 5'h13;  4'ha: c = 5'h16;  4'hb: c = 5'h17;
            4'hc: c = 5'h1a;  4'hd: c = 5'h1b;  4'he: c = 5'h1c;  default: c = 5'h1d;
        endcase
        return c;
    endfunction : encode_nib

    // code-group to {is_data, nibble}; anything else is not data
    function automatic logic [`NIB_W:0] decode_cg(input code_t c);
        logic [`NIB_W:0] r;
        r = 5'h00;
        for (int i = 0; i < 16; i++) begin
            if (encode_nib(nibble_t'(i)) == c) begin
                r = {1'b1, nibble_t'(i)};
            end
        end
        return r;
    endfunction : decode_cg
endpackage : line_codec_pkg
`default_nettype wire

/* verilog/stream_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
// synchronous fifo, flip-flop storage, honest full and empty
module stream_fifo #(
    parameter int W     = 5,
    parameter int DEPTH = 32
) (
    input  wire logic      sys_clk,
    input  wire logic      rst_n,
    stream_fifo_if.fifo    q
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_q [DEPTH];    // storage
    logic [AW:0]  wptr_q, wptr_d;   // write pointer, extra wrap bit
    logic [AW:0]  rptr_q, rptr_d;   // read pointer, extra wrap bit
    logic         wr, rd;           // accepted push and pop

    // full when pointers differ only in the wrap bit
    assign q.push_ready = !((wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]));
    assign q.pop_valid  = (wptr_q != rptr_q);
    assign q.pop_data   = mem_q[rptr_q[AW-1:0]];
    assign wr           = q.push_valid && q.push_ready;
    assign rd           = q.pop_valid && q.pop_ready;

    // pointer next values
    always_comb begin
        wptr_d = wr ? wptr_q + 1'b1 : wptr_q;
        rptr_d = rd ? rptr_q + 1'b1 : rptr_q;
    end

    // pointer registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wptr_q <= '0;
            rptr_q <= '0;
        end else begin
            wptr_q <= wptr_d;
            rptr_q <= rptr_d;
        end
    end

    // one entry per slot; data needs no reset
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        logic [W-1:0] ent_d;
        always_comb begin
            ent_d = (wr && (wptr_q[AW-1:0] == AW'(i))) ? q.push_data : mem_q[i];
        end
        always_ff @(posedge sys_clk) begin
            mem_q[i] <= ent_d;
        end
    end
endmodule : stream_fifo
`default_nettype wire

/* verilog/stream_fifo_if.sv */
`timescale 1ns/1ps
`default_nettype none
// push and pop handshakes of one fifo
interface stream_fifo_if #(parameter int W = 5);
    logic         push_valid;   // writer has a word
    logic         push_ready;   // fifo has room
    logic [W-1:0] push_data;    // word in
    logic         pop_valid;    // fifo has a word
    logic         pop_ready;    // reader takes it
    logic [W-1:0] pop_data;     // head word
    modport fifo (input push_valid, push_data, pop_ready,
                  output push_ready, pop_valid, pop_data);
    modport user (output push_valid, push_data, pop_ready,
                  input push_ready, pop_valid, pop_data);
endinterface : stream_fifo_if
`default_nettype wire
